/* hdl/vcd_dsp.sv */
// Voice codec transmit and receive sample processing with its APB register file.
// Summary of operation
// - Cascaded decimation to 8 kHz, final low-pass.
// - Tone path select inserts extra 2 kHz low-pass.
// - Tone-to-transmit flag adds tone to voice.
// - Transmit gain from two bytes, up to 12 dB.
// - Transmit gain bypassed until coefficients written.
// - Transmit equalizer set by twelve coefficient bytes.
// - Transmit equalizer bypassed after reset.
// - Transmit high-pass removes DC.
// - Format select, 8-bit masking, per-channel source.
// - Receive data expanded mirroring transmit format.
// - Sidetone adds scaled transmit signal to receive.
// - Sidetone gain muted after reset.
// - Receive high-pass removes mains hum.
// - Receive equalizer set by twelve bytes.
// - Receive equalizer bypassed after reset.
// - Receive gain from two coefficient bytes.
// - Receive gain bypassed after reset.
// - Receive band-limit, then cascaded interpolation to DAC.
// - Gain codes: A0 01 unity, 88 01 mute.
// - Tone unit configured by config and switch registers.
// - Transmit linear word kept as 16-bit two's complement.
//
// The APB slave port and the register addresses were decided locally.
`include "vcd_regs.svh"
module vcd_dsp
  import vcd_pkg::*;
(
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire vcd_sample_type     adc_in,
  input  wire logic signed [15:0] tone_sample,
  output logic      [7:0]         tone_config,
  output logic      [7:0]         tone_switch,
  output logic                    tx_valid,
  output vcd_frame_type           tx_frame,
  input  wire logic               rx_valid,
  input  wire vcd_frame_type      rx_frame,
  input  wire logic               dac_req,
  output logic signed [15:0]      dac_sample
);
  // ----------------------------------------------------------------
  // Arithmetic helpers
  // ----------------------------------------------------------------
  function automatic logic signed [15:0] vcd_sat(input logic signed [32:0] v);
    if (v > 33'sh00007fff)
      return 16'sh7fff;
    if (v < -33'sh00008000)
      return 16'sh8000;
    return v[15:0];
  endfunction

  // One-pole section: moves the state a 2^-sh fraction toward x.
  function automatic logic signed [15:0] vcd_step(input logic signed [15:0] s,
                                                   input logic signed [15:0] x,
                                                   input int sh);
    logic signed [17:0] d;
    d = (18'(x) - 18'(s)) >>> sh;
    return 16'(18'(s) + d);
  endfunction

  // Gain code to unsigned linear factor with 12 fraction bits.
  function automatic logic [15:0] vcd_gain(input logic [15:0] c);
    if (c == `VCD_GAIN_MUTE)
      return 16'h0000;
    if (c == `VCD_GAIN_UNITY)
      return `VCD_GAIN_ONE;
    return (c > `VCD_GAIN_MAX) ? `VCD_GAIN_MAX : c;
  endfunction

  function automatic logic signed [15:0] vcd_amp(input logic signed [15:0] x,
                                                  input logic [15:0] g);
    logic signed [32:0] p;
    p = 33'(x) * 33'($signed({1'b0, g}));
    return vcd_sat(p >>> `VCD_GAIN_SH);
  endfunction

  function automatic logic signed [15:0] vcd_fir(input logic [11:0][15:0] w,
                                                  input logic [11:0][7:0] c);
    logic signed [32:0] acc;
    acc = '0;
    for (int i = 0; i < `VCD_EQ_TAPS; i++)
      acc = acc + 33'($signed(w[i])) * 33'($signed(c[i]));
    return vcd_sat(acc >>> `VCD_EQ_SH);
  endfunction

  // ----------------------------------------------------------------
  // Companding
  // ----------------------------------------------------------------
  function automatic logic [7:0] vcd_alaw(input logic signed [15:0] x);
    logic [11:0] m;
    logic [2:0]  sg;
    m  = x[15] ? ~x[14:3] : x[14:3];
    sg = 3'h0;
    for (int i = 1; i < 8; i++)
      if (m[i+4])
        sg = 3'(i);
    return {~x[15], sg, 4'(m >> ((sg == 3'h0) ? 3'h1 : sg))} ^ 8'h55;
  endfunction

  function automatic logic signed [15:0] vcd_alaw_dec(input logic [7:0] c);
    logic [7:0]  v;
    logic [15:0] t;
    v = c ^ 8'h55;
    t = {8'h00, v[3:0], 4'h8};
    if (v[6:4] != 3'h0)
      t = t + 16'h0100;
    if (v[6:4] > 3'h1)
      t = t << (v[6:4] - 3'h1);
    return v[7] ? t : -t;
  endfunction

  function automatic logic [7:0] vcd_ulaw(input logic signed [15:0] x);
    logic [15:0] m;
    logic [2:0]  sg;
    m  = x[15] ? ~x : x;
    m  = ((m > 16'h7f7b) ? 16'h7f7b : m) + 16'h0084;
    sg = 3'h0;
    for (int i = 1; i < 8; i++)
      if (m[i+7])
        sg = 3'(i);
    return ~{x[15], sg, 4'(m >> ({1'b0, sg} + 4'h3))};
  endfunction

  function automatic logic signed [15:0] vcd_ulaw_dec(input logic [7:0] c);
    logic [7:0]  v;
    logic [15:0] t;
    v = ~c;
    t = (({9'h000, v[3:0], 3'h0}) + 16'h0084) << v[6:4];
    t = t - 16'h0084;
    return v[7] ? -t : t;
  endfunction

  function automatic logic [7:0] vcd_comp(input vcd_format_type f,
                                          input logic signed [15:0] x);
    case (f)
      VCD_FMT_ALAW: return vcd_alaw(x);
      VCD_FMT_ULAW: return vcd_ulaw(x);
      default:      return x[15:8];
    endcase
  endfunction

  function automatic logic signed [15:0] vcd_exp(input vcd_format_type f,
                                                  input logic [7:0] b,
                                                  input logic [15:0] lin);
    case (f)
      VCD_FMT_ALAW: return vcd_alaw_dec(b);
      VCD_FMT_ULAW: return vcd_ulaw_dec(b);
      VCD_FMT_LIN8: return {b, 8'h00};
      default:      return lin;
    endcase
  endfunction

  function automatic logic [7:0] vcd_src(input vcd_source_type s,
                                         input logic [7:0] v,
                                         input logic [7:0] tn,
                                         input logic [7:0] mk);
    case (s)
      VCD_SRC_VOICE: return v ^ mk;
      VCD_SRC_TONE:  return tn ^ mk;
      VCD_SRC_IDLE:  return 8'hff;
      default:       return 8'h00;
    endcase
  endfunction

  function automatic logic vcd_hit(input logic [7:0] a, input logic [7:0] off);
    return a == off;
  endfunction

  // ----------------------------------------------------------------
  // APB register file
  // ----------------------------------------------------------------
  logic [7:0]        ctrl;
  logic [7:0]        mask8;
  logic [15:0]       tx_gain;
  logic [15:0]       st_gain;
  logic [15:0]       rx_gain;
  logic              tx_g_act;
  logic              rx_g_act;
  logic [11:0][7:0]  tx_eq_c;
  logic [11:0][7:0]  rx_eq_c;
  logic [2:0]        txeq_hit;
  logic [2:0]        rxeq_hit;
  logic              wr_en;
  logic              mapped;
  logic [31:0]       rd_mux;
  logic signed [15:0] tx_lin;
  logic signed [15:0] rx_voice;

  assign wr_en  = psel & penable & pwrite & ~pslverr;
  genvar k;
  generate
    for (k = 0; k < 3; k++) begin : g_eq
      assign txeq_hit[k] = vcd_hit(paddr, `VCD_TXEQ + 8'(4 * k));
      assign rxeq_hit[k] = vcd_hit(paddr, `VCD_RXEQ + 8'(4 * k));
    end
  endgenerate
  assign mapped = vcd_hit(paddr, `VCD_CTRL) | vcd_hit(paddr, `VCD_MASK) |
                  vcd_hit(paddr, `VCD_TCFG) | vcd_hit(paddr, `VCD_TSW) |
                  vcd_hit(paddr, `VCD_TXG) | vcd_hit(paddr, `VCD_STG) |
                  vcd_hit(paddr, `VCD_RXG) | vcd_hit(paddr, `VCD_STAT) |
                  (|txeq_hit) | (|rxeq_hit);
  assign pready  = 1'b1;
  // A write to the read-only status word is flagged rather than silently dropped.
  assign pslverr = psel & penable & (~mapped | (pwrite & vcd_hit(paddr, `VCD_STAT)));

  always_comb begin
    case (paddr)
      `VCD_CTRL:          rd_mux = {22'h0, rx_g_act, tx_g_act, ctrl};
      `VCD_MASK:          rd_mux = {24'h0, mask8};
      `VCD_TCFG:          rd_mux = {24'h0, tone_config};
      `VCD_TSW:           rd_mux = {24'h0, tone_switch};
      `VCD_TXG:           rd_mux = {16'h0, tx_gain};
      `VCD_STG:           rd_mux = {16'h0, st_gain};
      `VCD_RXG:           rd_mux = {16'h0, rx_gain};
      `VCD_TXEQ:          rd_mux = tx_eq_c[3:0];
      `VCD_TXEQ + 8'h04:  rd_mux = tx_eq_c[7:4];
      `VCD_TXEQ + 8'h08:  rd_mux = tx_eq_c[11:8];
      `VCD_RXEQ:          rd_mux = rx_eq_c[3:0];
      `VCD_RXEQ + 8'h04:  rd_mux = rx_eq_c[7:4];
      `VCD_RXEQ + 8'h08:  rd_mux = rx_eq_c[11:8];
      `VCD_STAT:          rd_mux = {tx_lin, rx_voice};
      default:            rd_mux = 32'h0;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl        <= 8'h00;
      mask8       <= 8'h00;
      tone_config <= 8'h00;
      tone_switch <= 8'h00;
      tx_gain     <= `VCD_GAIN_UNITY;
      st_gain     <= `VCD_GAIN_MUTE;
      rx_gain     <= `VCD_GAIN_UNITY;
      tx_g_act    <= 1'b0;
      rx_g_act    <= 1'b0;
    end else begin
      if (wr_en & vcd_hit(paddr, `VCD_CTRL))
        ctrl <= pwdata[7:0];
      if (wr_en & vcd_hit(paddr, `VCD_MASK))
        mask8 <= pwdata[7:0];
      if (wr_en & vcd_hit(paddr, `VCD_TCFG))
        tone_config <= pwdata[7:0];
      if (wr_en & vcd_hit(paddr, `VCD_TSW))
        tone_switch <= pwdata[7:0];
      if (wr_en & vcd_hit(paddr, `VCD_TXG))
        tx_gain <= pwdata[15:0];
      if (wr_en & vcd_hit(paddr, `VCD_STG))
        st_gain <= pwdata[15:0];
      if (wr_en & vcd_hit(paddr, `VCD_RXG))
        rx_gain <= pwdata[15:0];
      // Once a gain code has been written the stage stays in the path.
      tx_g_act <= tx_g_act | (wr_en & vcd_hit(paddr, `VCD_TXG));
      rx_g_act <= rx_g_act | (wr_en & vcd_hit(paddr, `VCD_RXG));
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_eq_c <= '0;
      rx_eq_c <= '0;
    end else begin
      for (int i = 0; i < 3; i++) begin
        if (wr_en & txeq_hit[i])
          tx_eq_c[4*i +: 4] <= pwdata;
        if (wr_en & rxeq_hit[i])
          rx_eq_c[4*i +: 4] <= pwdata;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= 32'h0;
    else if (psel & ~penable)
      prdata <= rd_mux;
  end

  vcd_format_type fmt;
  vcd_source_type src0;
  vcd_source_type src1;
  logic           dtps;
  logic           ttx;
  logic [7:0]     mk;
  assign fmt  = vcd_format_type'(ctrl[`VCD_CTRL_FMT +: 2]);
  assign src0 = vcd_source_type'(ctrl[`VCD_CTRL_SRC0 +: 2]);
  assign src1 = vcd_source_type'(ctrl[`VCD_CTRL_SRC1 +: 2]);
  assign dtps = tone_switch[`VCD_TSW_DTPS];
  assign ttx  = tone_switch[`VCD_TSW_TTX];
  assign mk   = (fmt == VCD_FMT_LIN16) ? 8'h00 : mask8;

  // ----------------------------------------------------------------
  // Transmit path
  // ----------------------------------------------------------------
  logic               d1_ph;
  logic               d2_ph;
  logic               d1_v;
  logic               dec_v;
  logic signed [15:0] d1_hold;
  logic signed [15:0] d1_out;
  logic signed [15:0] d2_hold;
  logic signed [15:0] dec_x;
  logic signed [15:0] dlow_st;
  logic signed [15:0] dtf_st;
  logic signed [15:0] dc_st;
  logic [11:0][15:0]  tx_hist;
  logic [11:0][15:0]  tx_win;
  logic signed [15:0] dlow_y;
  logic signed [15:0] dtf_y;
  logic signed [15:0] tx_mix;
  logic signed [15:0] dc_y;
  logic signed [15:0] tx_eq_out;
  logic signed [15:0] tx_amp_out;
  logic               tx_stage_v;
  vcd_frame_type      next_tx_frame;

  // Two halving stages, each averaging sample pairs before dropping one.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d1_ph   <= 1'b0;
      d2_ph   <= 1'b0;
      d1_v    <= 1'b0;
      dec_v   <= 1'b0;
      d1_hold <= '0;
      d1_out  <= '0;
      d2_hold <= '0;
      dec_x   <= '0;
    end else begin
      d1_v  <= adc_in.valid & d1_ph;
      dec_v <= d1_v & d2_ph;
      if (adc_in.valid) begin
        d1_ph   <= ~d1_ph;
        d1_hold <= adc_in.data;
        d1_out  <= vcd_step(d1_hold, adc_in.data, 1);
      end
      if (d1_v) begin
        d2_ph   <= ~d2_ph;
        d2_hold <= d1_out;
        dec_x   <= vcd_step(d2_hold, d1_out, 1);
      end
    end
  end

  assign dlow_y     = vcd_step(dlow_st, dec_x, `VCD_DLOW_SH);
  assign dtf_y      = dtps ? vcd_step(dtf_st, dlow_y, `VCD_DTF_SH) : dlow_y;
  assign tx_mix     = ttx ? vcd_sat(33'(dtf_y) + 33'(tone_sample)) : dtf_y;
  assign dc_y       = vcd_sat(33'(tx_mix) - 33'(dc_st));
  assign tx_win     = {tx_hist[10:0], dc_y};
  assign tx_eq_out  = ctrl[`VCD_CTRL_TXEQ] ? vcd_fir(tx_win, tx_eq_c) : dc_y;
  assign tx_amp_out = tx_g_act ? vcd_amp(tx_eq_out, vcd_gain(tx_gain)) : tx_eq_out;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dlow_st    <= '0;
      dtf_st     <= '0;
      dc_st      <= '0;
      tx_hist    <= '0;
      tx_lin     <= '0;
      tx_stage_v <= 1'b0;
    end else begin
      tx_stage_v <= dec_v;
      if (dec_v) begin
        dlow_st <= dlow_y;
        dtf_st  <= dtps ? dtf_y : dtf_st;
        dc_st   <= vcd_step(dc_st, tx_mix, `VCD_DC_SH);
        tx_hist <= tx_win;
        tx_lin  <= tx_amp_out;
      end
    end
  end

  assign next_tx_frame.ch0 = vcd_src(src0, vcd_comp(fmt, tx_lin),
                                     vcd_comp(fmt, tone_sample), mk);
  assign next_tx_frame.ch1 = vcd_src(src1, vcd_comp(fmt, tx_lin),
                                     vcd_comp(fmt, tone_sample), mk);
  assign next_tx_frame.lin = tx_lin;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tx_valid <= 1'b0;
      tx_frame <= '0;
    end else begin
      tx_valid <= tx_stage_v;
      if (tx_stage_v)
        tx_frame <= next_tx_frame;
    end
  end

  // ----------------------------------------------------------------
  // Receive path
  // ----------------------------------------------------------------
  logic signed [15:0] rx_exp;
  logic signed [15:0] st_add;
  logic signed [15:0] rx_sum;
  logic signed [15:0] hum_st;
  logic signed [15:0] hum_y;
  logic [11:0][15:0]  rx_hist;
  logic [11:0][15:0]  rx_win;
  logic signed [15:0] rx_eq_out;
  logic signed [15:0] rx_amp_out;
  logic signed [15:0] blim_y;
  logic signed [15:0] int1;
  logic signed [15:0] int2;

  assign rx_exp     = vcd_exp(fmt, rx_frame.ch0 ^ mk, rx_frame.lin);
  assign st_add     = vcd_amp(tx_lin, vcd_gain(st_gain));
  assign rx_sum     = vcd_sat(33'(rx_exp) + 33'(st_add));
  assign hum_y      = vcd_sat(33'(rx_sum) - 33'(hum_st));
  assign rx_win     = {rx_hist[10:0], hum_y};
  assign rx_eq_out  = ctrl[`VCD_CTRL_RXEQ] ? vcd_fir(rx_win, rx_eq_c) : hum_y;
  assign rx_amp_out = rx_g_act ? vcd_amp(rx_eq_out, vcd_gain(rx_gain)) : rx_eq_out;
  assign blim_y     = vcd_step(rx_voice, rx_amp_out, `VCD_BLIM_SH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hum_st   <= '0;
      rx_hist  <= '0;
      rx_voice <= '0;
    end else if (rx_valid) begin
      hum_st   <= vcd_step(hum_st, rx_sum, `VCD_HUM_SH);
      rx_hist  <= rx_win;
      rx_voice <= blim_y;
    end
  end

  // Held 8 kHz sample smoothed by two one-pole stages at the converter rate.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int1       <= '0;
      int2       <= '0;
      dac_sample <= '0;
    end else if (dac_req) begin
      int1       <= vcd_step(int1, rx_voice, `VCD_INT_SH);
      int2       <= vcd_step(int2, int1, `VCD_INT_SH);
      dac_sample <= int2;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking vcd_cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_read;
    psel && penable && !pwrite;
  endsequence

  AST_TX_LAT: assert property (dec_v |-> ##2 tx_valid)
    else $error("transmit frame not produced two cycles after decimated sample");
  AST_TX_BYPASS: assert property ((dec_v && !ctrl[0] && !tx_g_act) |=>
    (tx_lin == $past(dc_y))) else $error("transmit stages not bypassed");
  AST_GAIN_ARM: assert property ((wr_en && paddr == 8'h10) |=> tx_g_act[*3])
    else $error("transmit gain not armed by coefficient write");
  AST_STONE_MUTE: assert property ((st_gain == 16'h8801) |-> (st_add == 16'sh0000))
    else $error("sidetone added while muted");
  AST_TX_SAT: assert property ((tx_g_act && tx_eq_out > 0) |-> (tx_amp_out >= 0))
    else $error("transmit gain wrapped");
  AST_ALAW_ZERO: assert property ((tx_stage_v && ctrl[7:2] == 6'h00 && mask8 == 8'h00 &&
    tx_lin == 16'sh0000) |=> (tx_frame.ch0 == 8'hd5)) else $error("A-law zero code wrong");
  AST_RX_LAT: assert property (rx_valid |=> (rx_voice == $past(blim_y)))
    else $error("receive sample not taken");
  AST_APB_ERR: assert property ((psel && penable && !mapped) |-> pslverr && !wr_en)
    else $error("unmapped access not refused");
  AST_APB_RD: assert property ((s_setup ##1 s_read) |-> (prdata == $past(rd_mux)))
    else $error("read data not captured in setup");
endmodule

/* hdl/vcd_pkg.sv */
// Types shared by the voice codec DSP and its bench.
package vcd_pkg;
  typedef enum logic [1:0] {
    VCD_FMT_ALAW  = 2'b00,
    VCD_FMT_ULAW  = 2'b01,
    VCD_FMT_LIN8  = 2'b10,
    VCD_FMT_LIN16 = 2'b11
  } vcd_format_type;
  typedef enum logic [1:0] {
    VCD_SRC_VOICE = 2'b00,
    VCD_SRC_TONE  = 2'b01,
    VCD_SRC_IDLE  = 2'b10,
    VCD_SRC_ZERO  = 2'b11
  } vcd_source_type;
  typedef struct packed {
    logic [7:0]  ch0;
    logic [7:0]  ch1;
    logic [15:0] lin;
  } vcd_frame_type;
  typedef struct packed {
    logic        valid;
    logic [15:0] data;
  } vcd_sample_type;
endpackage

/* hdl/vcd_regs.svh */
// Register offsets, field positions, reset values and filter constants of the voice codec DSP.
`ifndef VCD_REGS_SVH
`define VCD_REGS_SVH
`define VCD_CTRL        8'h00
`define VCD_MASK        8'h04
`define VCD_TCFG        8'h08
`define VCD_TSW         8'h0c
`define VCD_TXG         8'h10
`define VCD_STG         8'h14
`define VCD_RXG         8'h18
`define VCD_TXEQ        8'h20
`define VCD_RXEQ        8'h30
`define VCD_STAT        8'h40
`define VCD_CTRL_TXEQ   0
`define VCD_CTRL_RXEQ   1
`define VCD_CTRL_FMT    2
`define VCD_CTRL_SRC0   4
`define VCD_CTRL_SRC1   6
`define VCD_TSW_DTPS    0
`define VCD_TSW_TTX     1
`define VCD_GAIN_UNITY  16'ha001
`define VCD_GAIN_MUTE   16'h8801
`define VCD_GAIN_ONE    16'h1000
`define VCD_GAIN_MAX    16'h3fb8
`define VCD_GAIN_SH     12
`define VCD_EQ_TAPS     12
`define VCD_EQ_SH       6
`define VCD_DLOW_SH     1
`define VCD_DTF_SH      1
`define VCD_DC_SH       6
`define VCD_HUM_SH      5
`define VCD_BLIM_SH     1
`define VCD_INT_SH      2
`endif

/* tb/vcd_dsp_tb.sv */
// Self-checking bench of the voice codec DSP with scoreboarded results.
`include "vcd_regs.svh"
module vcd_dsp_tb
  import vcd_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int GAP = 4;
  localparam logic [7:0] CHZ [4] = '{8'hd5, 8'hff, 8'h00, 8'h00};
  localparam logic [7:0] ADR [9] = '{`VCD_CTRL, `VCD_MASK, `VCD_TCFG, `VCD_TSW, `VCD_TXG,
                                     `VCD_STG, `VCD_RXG, `VCD_TXEQ, `VCD_RXEQ + 8'h08};
  localparam logic [31:0] VAL [9] = '{0, 0, 0, 0, `VCD_GAIN_UNITY, `VCD_GAIN_MUTE,
                                      `VCD_GAIN_UNITY, 0, 0};
  typedef struct packed {
    logic [31:0] d;
    logic [31:0] care;
    logic        err;
  } vcd_note_type;
  logic               pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
  logic               pwrite = 1'b0, rnd = 1'b0;
  logic [7:0]         paddr = '0, tone_config, tone_switch;
  logic [31:0]        pwdata = '0, prdata, seed = 32'h137fa1b5, rs = 32'h137fa1b5;
  logic               pready, pslverr, tx_valid, rx_valid, dac_req;
  logic [15:0]        adc_level = '0;
  logic signed [15:0] tone_sample = '0, dac_sample;
  vcd_sample_type     adc_in;
  vcd_frame_type      tx_frame, rx_frame;
  vcd_note_type       aq[$], fq[$], an, fn;
  int                 n_fail = 0, n_tests = 0, period = -1;
  logic               st_on = 1'b0;
  logic signed [15:0] st_in, hum_m, rx_m, i1_m, i2_m, dac_m;

  always #20 pclk = ~pclk;

  vcd_dsp dut_u (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .adc_in, .tone_sample, .tone_config, .tone_switch, .tx_valid,
    .tx_frame, .rx_valid, .rx_frame, .dac_req, .dac_sample);
  vcd_far_end #(.ADC_GAP(GAP)) far_u (.pclk, .presetn, .adc_level, .tx_valid, .adc_in,
    .rx_valid, .rx_frame, .dac_req);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic logic signed [15:0] ref_sat(input int v);
    return (v > 32767) ? 16'sh7fff : ((v < -32768) ? 16'sh8000 : 16'(v));
  endfunction

  // One-pole reference section: moves s a 2^-sh fraction toward x.
  function automatic logic signed [15:0] ref_step(input logic signed [15:0] s, x,
                                                  input int sh);
    return 16'(int'(s) + ((int'(x) - int'(s)) >>> sh));
  endfunction

  task automatic cmp(input string what, input logic [31:0] exp, seen, care);
    n_tests++;
    if ((seen & care) !== (exp & care)) begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", what, exp & care, seen & care);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd, exp, care,
                     input logic err);
    aq.push_back('{exp, care, err});
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic skip(input int n);
    repeat (n) @(negedge pclk iff tx_valid === 1'b1);
  endtask

  // The note goes in ahead of the frame it describes, so later settings cannot reach it.
  task automatic frame(input logic [31:0] exp, care);
    @(posedge pclk);
    fq.push_back('{exp, care, 1'b0});
    skip(1);
  endtask

  task automatic tally_and_finish;
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ----------------------------------------
  // Result watchers
  // ----------------------------------------
  always @(posedge pclk) if (psel && penable && pready === 1'b1 && aq.size() > 0) begin
    an = aq.pop_front();
    cmp("prdata", an.d, prdata, an.care);
    cmp("pslverr", {31'b0, an.err}, {31'b0, pslverr}, 32'h1);
  end

  always @(negedge pclk) begin
    if (!presetn) period = -1;
    else if (period >= 0) period++;
    if (tx_valid === 1'b1) begin
      if (period > 0) cmp("frame period", 4 * GAP, period, '1);
      period = 0;
      if (fq.size() > 0) begin
        fn = fq.pop_front();
        cmp("tx_frame", fn.d, tx_frame, fn.care);
      end
    end
  end

  always @(posedge pclk) if (rnd) begin
    rs        <= lfsr(rs);
    adc_level <= rs[15:0];
  end

  // Receive reference: linear input is zero, so only the sidetone feeds the chain.
  assign st_in = st_on ? tx_frame.lin : 16'sh0000;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {hum_m, rx_m, i1_m, i2_m, dac_m} <= '0;
    end else begin
      if (rx_valid) begin
        hum_m <= ref_step(hum_m, st_in, `VCD_HUM_SH);
        rx_m  <= ref_step(rx_m, ref_sat(int'(st_in) - int'(hum_m)), `VCD_BLIM_SH);
      end
      if (dac_req) begin
        i1_m  <= ref_step(i1_m, rx_m, `VCD_INT_SH);
        i2_m  <= ref_step(i2_m, i1_m, `VCD_INT_SH);
        dac_m <= i2_m;
      end
    end
  end

  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    foreach (ADR[i]) apb(0, ADR[i], 0, VAL[i], '1, 0);
    apb(0, 8'h44, 0, 0, '1, 1);
    apb(1, `VCD_STAT, 32'hffff, 0, 0, 1);
    seed = lfsr(seed);
    apb(1, `VCD_TCFG, seed, 0, 0, 0);
    apb(1, `VCD_TSW, (seed >> 8) & 32'hfc, 0, 0, 0);
    apb(0, `VCD_TCFG, 0, {24'h0, seed[7:0]}, '1, 0);
    cmp("tone_config", {24'h0, seed[7:0]}, {24'h0, tone_config}, '1);
    cmp("tone_switch", {24'h0, seed[15:10], 2'b0}, {24'h0, tone_switch}, '1);
    for (int f = 0; f < 4; f++) begin
      apb(1, `VCD_CTRL, {f[1:0], 2'b0} | 32'h80, 0, 0, 0);
      skip(3);
      frame({CHZ[f], 8'hff, 16'h0}, f == 3 ? 32'h00ffffff : '1);
    end
    apb(1, `VCD_MASK, 32'h5a, 0, 0, 0);
    apb(1, `VCD_CTRL, 32'hc8, 0, 0, 0);
    skip(3);
    frame(32'h5a000000, 32'hff000000);
    apb(1, `VCD_MASK, 0, 0, 0, 0);
    apb(1, `VCD_CTRL, 32'h18, 0, 0, 0);
    tone_sample <= 16'sh3400;
    skip(3);
    frame(32'h34000000, 32'hff000000);
    apb(1, `VCD_CTRL, 32'h08, 0, 0, 0);
    apb(1, `VCD_TSW, 32'h02, 0, 0, 0);
    skip(3);
    cmp("tone mixed", 1, {31'b0, tx_frame.lin != 16'h0}, 1);
    apb(1, `VCD_TSW, 0, 0, 0, 0);
    // A second reset clears the filter history so the receive reference starts from zero.
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1, `VCD_CTRL, 32'h0c, 0, 0, 0);
    rnd <= 1'b1;
    skip(4);
    apb(0, `VCD_STAT, 0, 0, 32'hffff, 0);
    apb(1, `VCD_STG, `VCD_GAIN_UNITY, 0, 0, 0);
    st_on <= 1'b1;
    skip(2);
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    cmp("dac_sample", {16'h0, dac_m}, {16'h0, dac_sample}, '1);
    apb(0, `VCD_STAT, 0, {tx_frame.lin, rx_m}, '1, 0);
    apb(1, `VCD_TXG, `VCD_GAIN_MUTE, 0, 0, 0);
    apb(1, `VCD_RXG, `VCD_GAIN_UNITY, 0, 0, 0);
    apb(0, `VCD_CTRL, 0, 32'h30c, 32'h3ff, 0);
    skip(4);
    repeat (3) frame(0, 32'hffff);
    @(posedge pclk);
    tally_and_finish();
  end
endmodule

/* tb/vcd_far_end.sv */
// Far-end model: oversampling converters and frame handler around the DSP.
module vcd_far_end
  import vcd_pkg::*;
#(
  parameter int ADC_GAP = 4
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [15:0] adc_level,
  input  wire logic        tx_valid,
  output vcd_sample_type   adc_in,
  output logic             rx_valid,
  output vcd_frame_type    rx_frame,
  output logic             dac_req
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt;
  // Between samples the data lines toggle, so a capture off the strobe shows up.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt      <= 0;
      adc_in   <= '0;
      rx_valid <= 1'b0;
      rx_frame <= '1;
      dac_req  <= 1'b0;
    end else begin
      cnt          <= (cnt == ADC_GAP - 1) ? 0 : cnt + 1;
      adc_in.valid <= (cnt == 0);
      adc_in.data  <= (cnt == 0) ? adc_level : ~adc_in.data;
      rx_valid     <= tx_valid;
      rx_frame     <= tx_valid ? '0 : '1;
      dac_req      <= (cnt == 1);
    end
  end
endmodule
